// *** design/fbp_pkg.sv ***
// shared constants and carrier types for the flash block protection unit
package fbp_pkg;
    // =========================================================
    // array geometry
    localparam int unsigned FLASH_BYTES   = 65536;  // 64 KB array
    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned WORD_W        = 32;
    localparam int unsigned WORD_ADDR_W   = 14;     // word index bits
    localparam int unsigned BLK_LSB       = 10;     // 1 KB erase block
    localparam int unsigned REG_LSB       = 11;     // 2 KB protect region
    localparam int unsigned NUM_BLOCKS    = 64;
    localparam int unsigned NUM_REGIONS   = 32;
    localparam int unsigned WORDS_PER_BLK = 256;
    localparam logic [31:0] ERASED_WORD   = 32'hFFFFFFFF;
    localparam logic [31:0] DENIED_WORD   = 32'h00000000;
    localparam logic [31:0] PROT_RESET    = 32'h00000000;

    // =========================================================
    // carrier types
    typedef enum logic [1:0] {
        FBP_OP_NONE,
        FBP_OP_PROGRAM,
        FBP_OP_ERASE
    } fbp_op_t;

    typedef struct packed {
        fbp_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [WORD_W-1:0]   wdata;
    } fbp_wreq_t;

    typedef struct packed {
        logic                valid;
        logic                fetch;   // 1 = instruction fetch path
        logic [ADDR_W-1:0]   addr;
    } fbp_rreq_t;
endpackage

// *** design/fbp_prot_check.sv ***
// protection lookup for one access address
`timescale 1ns/1ns
module fbp_prot_check (
    input  wire logic [15:0] addr_i,
    input  wire logic [31:0] ro_mask_i,
    input  wire logic [31:0] xo_mask_i,
    input  wire logic        fetch_i,
    output logic             wr_deny_o,
    output logic             rd_deny_o
);
    logic [4:0] region;

    // =========================================================
    // region select and decision
    assign region    = addr_i[15:11];
    // either mark blocks erase and program
    assign wr_deny_o = ro_mask_i[region] | xo_mask_i[region];
    // execute-only serves the fetch path only
    assign rd_deny_o = xo_mask_i[region] & ~fetch_i;
endmodule

// *** design/fbp_flash.sv ***
// flash array with per-region read-only and execute-only protection
`timescale 1ns/1ns
module fbp_flash #(
    parameter int unsigned NUM_REGIONS = fbp_pkg::NUM_REGIONS
) (
    input  wire logic                ref_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic [31:0]         ro_mask_i,
    input  wire logic [31:0]         xo_mask_i,
    input  wire fbp_pkg::fbp_rreq_t  rreq_i,
    output logic [31:0]              rdata_o,
    output logic                     rvalid_o,
    output logic                     rdenied_o,
    input  wire fbp_pkg::fbp_wreq_t  wreq_i,
    output logic                     wbusy_o,
    output logic                     wdone_o,
    output logic                     wrefused_o
);
    typedef enum logic [1:0] {
        FBP_IDLE,
        FBP_ERASING
    } fbp_state_t;

    logic [31:0]      mem [0:16383];
    fbp_state_t       state_q, state_d;
    logic [7:0]       ecnt_q, ecnt_d;
    logic [5:0]       eblk_q, eblk_d;
    logic [31:0]      rdata_q, rdata_d;
    logic             rvalid_q, rvalid_d;
    logic             rden_q, rden_d;
    logic             wdone_q, wdone_d;
    logic             wref_q, wref_d;
    logic             rd_deny;
    logic             wr_deny;
    logic             prog_en;
    logic [13:0]      mem_waddr;
    logic [31:0]      mem_wdata;
    logic             mem_we;
    logic [31:0]      ro_eff;
    logic [31:0]      xo_eff;

    // only the configured regions can be marked
    assign ro_eff = ro_mask_i & ((32'h1 << NUM_REGIONS) - 32'h1);
    assign xo_eff = xo_mask_i & ((32'h1 << NUM_REGIONS) - 32'h1);

    // =========================================================
    // read protection lookup
    fbp_prot_check u_rd_chk (
        .addr_i    (rreq_i.addr),
        .ro_mask_i (ro_eff),
        .xo_mask_i (xo_eff),
        .fetch_i   (rreq_i.fetch),
        .wr_deny_o (),
        .rd_deny_o (rd_deny)
    );

    // write lookup; a write is never a fetch
    fbp_prot_check u_wr_chk (
        .addr_i    (wreq_i.addr),
        .ro_mask_i (ro_eff),
        .xo_mask_i (xo_eff),
        .fetch_i   (1'b0),
        .wr_deny_o (wr_deny),
        .rd_deny_o ()
    );

    // =========================================================
    // write and erase sequencing
    always_comb begin
        state_d   = state_q;
        ecnt_d    = ecnt_q;
        eblk_d    = eblk_q;
        wdone_d   = 1'b0;
        wref_d    = 1'b0;
        prog_en   = 1'b0;
        mem_we    = 1'b0;
        mem_waddr = {eblk_q, ecnt_q};
        mem_wdata = fbp_pkg::ERASED_WORD;
        case (state_q)
            FBP_IDLE: begin
                if (wreq_i.op != fbp_pkg::FBP_OP_NONE) begin
                    if (wr_deny) begin
                        wref_d = 1'b1;
                        wdone_d = 1'b1;
                    end else if (wreq_i.op == fbp_pkg::FBP_OP_PROGRAM) begin
                        prog_en = 1'b1;
                        wdone_d = 1'b1;
                    end else begin
                        eblk_d  = wreq_i.addr[15:10];
                        ecnt_d  = 8'h00;
                        state_d = FBP_ERASING;
                    end
                end
                if (prog_en) begin
                    mem_we    = 1'b1;
                    mem_waddr = wreq_i.addr[15:2];
                    // flash programming only clears bits
                    mem_wdata = mem[wreq_i.addr[15:2]] & wreq_i.wdata;
                end
            end
            FBP_ERASING: begin
                mem_we = 1'b1;
                ecnt_d = ecnt_q + 8'h01;
                if (ecnt_q == 8'hFF) begin
                    wdone_d = 1'b1;
                    state_d = FBP_IDLE;
                end
            end
            default: state_d = FBP_IDLE;
        endcase
    end

    // register the sequencer; outputs restart idle after reset
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_q <= FBP_IDLE;
            ecnt_q  <= 8'h00;
            eblk_q  <= 6'h00;
            wdone_q <= 1'b0;
            wref_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            ecnt_q  <= ecnt_d;
            eblk_q  <= eblk_d;
            wdone_q <= wdone_d;
            wref_q  <= wref_d;
        end
    end

    // array storage has no reset; contents survive reset like flash
    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // =========================================================
    // single-cycle read path
    always_comb begin
        rvalid_d = rreq_i.valid;
        rden_d   = rreq_i.valid & rd_deny;
        rdata_d  = rdata_q;
        if (rreq_i.valid) begin
            rdata_d = rd_deny ? fbp_pkg::DENIED_WORD
                              : mem[rreq_i.addr[15:2]];
        end
    end

    // register the read answer; data holds until the next read
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            rden_q   <= 1'b0;
            rdata_q  <= fbp_pkg::DENIED_WORD;
        end else begin
            rvalid_q <= rvalid_d;
            rden_q   <= rden_d;
            rdata_q  <= rdata_d;
        end
    end

    // all answers come from flops except the busy level
    assign rdata_o    = rdata_q;
    assign rvalid_o   = rvalid_q;
    assign rdenied_o  = rden_q;
    assign wdone_o    = wdone_q;
    assign wrefused_o = wref_q;
    assign wbusy_o    = (state_q != FBP_IDLE);

    // =========================================================
    // checks
    chk_read_latency : assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) rreq_i.valid |=> rvalid_o)
        else $error("read not answered next cycle");
    chk_deny_zero : assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) rdenied_o |-> rdata_o == 32'h0)
        else $error("denied read leaked data");
    chk_xo_fetch : assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        rreq_i.valid && rreq_i.fetch |=> !rdenied_o)
        else $error("fetch was denied");
    chk_xo_data : assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        rreq_i.valid && !rreq_i.fetch
        && xo_eff[rreq_i.addr[15:11]] |=> rdenied_o)
        else $error("data read of execute-only served");
    chk_ro_refuse : assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        state_q == FBP_IDLE && wreq_i.op != fbp_pkg::FBP_OP_NONE
        && ro_eff[wreq_i.addr[15:11]] |-> !mem_we ##1 wrefused_o)
        else $error("read-only write not refused");
    chk_erase_len : assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        $rose(wbusy_o) |-> ##255 wbusy_o ##1 !wbusy_o && wdone_o)
        else $error("erase not 256 cycles");
    chk_erase_ones : assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        wbusy_o |-> mem_we && mem_wdata == 32'hFFFFFFFF
        && mem_waddr[13:8] == eblk_q)
        else $error("erase wrote wrong word or block");
    chk_refuse_done : assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) wrefused_o |-> wdone_o && !$past(mem_we))
        else $error("refused write touched array");
    // execute-only marks refuse writes just like read-only ones
    chk_xo_refuse : assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        state_q == FBP_IDLE && wreq_i.op != fbp_pkg::FBP_OP_NONE
        && xo_eff[wreq_i.addr[15:11]] |-> !mem_we ##1 wrefused_o)
        else $error("execute-only write not refused");
    // an answer only ever follows a request one cycle earlier
    chk_read_clear : assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) !rreq_i.valid |=> !rvalid_o)
        else $error("read answer without request");
endmodule

// *** test/fbp_bus_model.sv ***
// bus-side model issuing flash reads, programs and erases
`timescale 1ns/1ns
module fbp_bus_model (
    input  wire logic         ref_clk_i,
    input  wire logic [31:0]  rdata_i,
    input  wire logic         rvalid_i,
    input  wire logic         rdenied_i,
    input  wire logic         wdone_i,
    input  wire logic         wrefused_i,
    output fbp_pkg::fbp_rreq_t rreq_o,
    output fbp_pkg::fbp_wreq_t wreq_o
);
    // =========================================================
    // idle requests from time zero
    initial begin
        rreq_o = '0;
        wreq_o = '0;
    end
    // one read; released fields show inverted values, not the last ones
    task automatic rd(input logic f, input logic [15:0] a,
                      output logic [31:0] d, output logic v, dn);
        @(posedge ref_clk_i);
        rreq_o <= {1'b1, f, a};
        @(posedge ref_clk_i);
        rreq_o <= {1'b0, ~f, ~a};
        @(posedge ref_clk_i);
        d = rdata_i;
        v = rvalid_i;
        dn = rdenied_i;
    endtask
    // one write; n counts edges to done, 0 means it never came
    task automatic wr(input fbp_pkg::fbp_op_t op, input logic [15:0] a,
                      input logic [31:0] d, output int n, output logic rf);
        n = 0;
        rf = 1'b0;
        @(posedge ref_clk_i);
        wreq_o <= {op, a, d};
        @(posedge ref_clk_i);
        wreq_o <= {fbp_pkg::FBP_OP_NONE, ~a, ~d};
        for (int i = 1; i <= 400 && n == 0; i++) begin
            @(posedge ref_clk_i);
            if (wdone_i === 1'b1) begin
                n = i;
                rf = wrefused_i;
            end
        end
    endtask
endmodule

// *** test/fbp_flash_tb.sv ***
// self-checking bench for the flash block protection unit
`timescale 1ns/1ns
module fbp_flash_tb;
    logic               ref_clk_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic [31:0]        ro_mask = 32'h00000000;
    logic [31:0]        xo_mask = 32'h00000000;
    fbp_pkg::fbp_rreq_t rreq;
    fbp_pkg::fbp_wreq_t wreq;
    logic [31:0]        rdata;
    logic               rvalid, rdenied, wbusy, wdone, wrefused;
    logic [31:0]        shadow [0:16383];
    int                 fail_count = 0;
    int                 cmp_count = 0;
    int                 seed = 45;
    logic [15:0]        a;
    // =========================================================
    // clock and instances
    always #10 ref_clk_i = ~ref_clk_i;
    fbp_flash i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .ro_mask_i(ro_mask), .xo_mask_i(xo_mask), .rreq_i(rreq),
        .rdata_o(rdata), .rvalid_o(rvalid), .rdenied_o(rdenied),
        .wreq_i(wreq), .wbusy_o(wbusy), .wdone_o(wdone),
        .wrefused_o(wrefused));
    fbp_bus_model i_bus (.ref_clk_i(ref_clk_i), .rdata_i(rdata),
        .rvalid_i(rvalid), .rdenied_i(rdenied), .wdone_i(wdone),
        .wrefused_i(wrefused), .rreq_o(rreq), .wreq_o(wreq));
    // =========================================================
    // compares and verdict
    task automatic check_word(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s exp %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_flag(input string nm, input logic e, g);
        check_word(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic print_verdict();
        $display("mismatches %0d compares %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // protection of the region holding an address
    function automatic logic locked(input logic [15:0] ad);
        return ro_mask[ad[15:11]] | xo_mask[ad[15:11]];
    endfunction
    // =========================================================
    // write with expectation, shadow updated only when accepted
    task automatic op(input fbp_pkg::fbp_op_t o, input logic [15:0] ad,
                      input logic [31:0] d);
        int n;
        logic rf;
        logic er;
        er = (o == fbp_pkg::FBP_OP_ERASE);
        i_bus.wr(o, ad, d, n, rf);
        if (n == 0) begin
            fail_count++;
            print_verdict();
        end
        check_word("done delay",
                   (er && !locked(ad)) ? 32'h00000101 : 32'h00000001,
                   n);
        check_flag("refused", locked(ad), rf);
        if (!locked(ad) && er)
            for (int i = 0; i < 256; i++)
                shadow[{ad[15:10], i[7:0]}] = fbp_pkg::ERASED_WORD;
        else if (!locked(ad))
            shadow[ad[15:2]] = shadow[ad[15:2]] & d;
    endtask
    // read with expectation; data reads of execute-only come back empty
    task automatic rdchk(input logic f, input logic [15:0] ad);
        logic [31:0] d;
        logic v, dn, den;
        den = xo_mask[ad[15:11]] & !f;
        i_bus.rd(f, ad, d, v, dn);
        check_flag("rvalid", 1'b1, v);
        check_flag("rdenied", den, dn);
        check_word("rdata", den ? fbp_pkg::DENIED_WORD
                                : shadow[ad[15:2]], d);
    endtask
    // =========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk_i);
        check_flag("busy in reset", 1'b0, wbusy);
        rst_n_i <= 1'b1;
        for (int b = 0; b < 4; b++)
            op(fbp_pkg::FBP_OP_ERASE, {b[5:0], 10'h155}, 32'h0);
        op(fbp_pkg::FBP_OP_ERASE, 16'hFC00, 32'h0);
        op(fbp_pkg::FBP_OP_PROGRAM, 16'h03FC, 32'h0000FFFF);
        rdchk(1'b0, 16'h0400);
        rdchk(1'b0, 16'h03FC);
        // random masks over regions 0 and 1 (execute-only also region 31), programs and erases
        for (int k = 0; k < 40; k++) begin
            @(posedge ref_clk_i);
            ro_mask <= $random(seed) & 32'h00000003;
            xo_mask <= $random(seed) & $random(seed) & 32'h80000003;
            @(posedge ref_clk_i);
            a = 16'($random(seed)) & 16'h0FFF;
            op(($random(seed) & 7) == 0 ? fbp_pkg::FBP_OP_ERASE
                : fbp_pkg::FBP_OP_PROGRAM, a,
                $random(seed) | $random(seed));
            rdchk(1'b0, a);
            rdchk(1'b1, a);
            rdchk(1'b0, 16'hFFFC);
        end
        print_verdict();
    end
endmodule
